//--- shared/adcc_pkg.sv
// Package for the converter control and result block.
// Holds register offsets, field positions, reset values and timing counts.
`default_nettype none
package adcc_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets on the Avalon-MM bus
  // ---------------------------------------------------------------
  localparam logic [3:0] ADCC_OFF_INPUT_SELECT = 4'h0;
  localparam logic [3:0] ADCC_OFF_CONTROL      = 4'h4;
  localparam logic [3:0] ADCC_OFF_RESULT_LOW   = 4'h8;
  localparam logic [3:0] ADCC_OFF_RESULT_HIGH  = 4'hC;
  localparam logic [4:0] ADCC_OFF_TRIG_SRC     = 5'h10;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ADCC_BIT_ENABLE     = 7;
  localparam int ADCC_BIT_START      = 6;
  localparam int ADCC_BIT_AUTO       = 5;
  localparam int ADCC_BIT_DONE       = 4;
  localparam int ADCC_BIT_DONE_IE    = 3;
  localparam int ADCC_BIT_LEFT_ADJ   = 5;
  // ---------------------------------------------------------------
  // Reset values and timing counts
  // ---------------------------------------------------------------
  localparam logic [7:0] ADCC_RESET_BYTE   = 8'h00;
  localparam logic [4:0] ADCC_FIRST_CYCLES = 5'h19; // 25 converter clocks.
  localparam logic [4:0] ADCC_NORM_CYCLES  = 5'h0D; // 13 converter clocks.
  localparam logic [4:0] ADCC_SE_LAST      = 5'h07;
  localparam logic [4:0] ADCC_BANDGAP      = 5'h1E;
  localparam logic [4:0] ADCC_GROUND       = 5'h1F;
  localparam logic [4:0] ADCC_DIFF_FIRST   = 5'h08;
  localparam logic [4:0] ADCC_DIFF_LAST    = 5'h1D;
  localparam logic [4:0] ADCC_GAIN_LAST    = 5'h0F;
  localparam logic [2:0] ADCC_FREE_RUNNING = 3'h0;
  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_CONV = 2'b01
  } adcc_state_t;
endpackage
`default_nettype wire

//--- hdl/adcc_clock_divider.sv
// Converter clock divider: one-cycle enable pulse every 2 to 128 system clocks.
// Assumes the select code is held static by software while converting.
`timescale 1ns/1ps
`default_nettype none
module adcc_clock_divider
  import adcc_pkg::*;
#(
  parameter int WIDTH = 7
)
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] divider_select,
  output logic            tick
);
  // The limit decode below is written for a seven-bit count.
  if (WIDTH != 7)
  begin : g_width_check
    $error("adcc_clock_divider supports only WIDTH 7");
  end

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] limit;

  // ---------------------------------------------------------------
  // Terminal count
  // ---------------------------------------------------------------
  // divide factor decode
  // Codes 0 and 1 both divide by two.
  always_comb
  begin
    if (divider_select <= 3'h1)
      limit = 7'h01;
    else
      limit = WIDTH'((8'h01 << divider_select) - 8'h01);
  end

  // Counter restarts when idle so every conversion sees whole periods.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= '0;
    else if (!run || count_reg >= limit)
      count_reg <= '0;
    else
      count_reg <= count_reg + 7'h01;
  end

  assign tick = run && (count_reg >= limit);

  tick_space_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tick && divider_select <= 3'h1 && $stable(divider_select) ##1 run |-> !tick ##1 (tick || !run))
    else $error("divide by two tick spacing wrong");
endmodule // adcc_clock_divider
`default_nettype wire

//--- hdl/adcc_top.sv
// Converter control and result registers behind an Avalon-MM slave.
// Assumes the conversion core returns a 10-bit code when asked; the
// trigger sources and global interrupt enable come in as plain levels.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Channel and gain latched per conversion.
// - Codes 0-7 single inputs, bandgap, ground.
// - Codes 8-29 select differential pairs and gain.
// - Enable powers; clearing aborts conversion.
// - Start bit begins single or first conversion.
// - First conversion 25 clocks, then 13.
// - Start reads one while busy; zero ignored.
// - Auto trigger starts on trigger rising edge.
// - Done flag sets when results updated.
// - Done cleared by vector or writing one.
// - Interrupt when flag, enable, global set.
// - Prescaler divides system clock 2 to 128.
// - Right adjust: high holds 9:8, low 7:0.
// - Left adjust: high 9:2, low 1:0 top.
// - Low read locks results until high read.
// - Differential results shown as the core returns them.
// - Left adjust change shows at once.
// - Trigger source select; free running no trigger.
module adcc_top
  import adcc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]     avs_readdata,
  output logic            avs_waitrequest,
  input  wire logic [7:1] trigger_sources,
  input  wire logic       global_irq_enable,
  input  wire logic       done_vector_ack,
  input  wire logic [9:0] core_result,
  output logic            core_power,
  output logic            core_sample,
  output logic [4:0]      core_input_gain_select,
  output logic            core_differential,
  output logic            done_irq
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [4:0]  input_gain_select_reg;
  logic        left_adjust_reg;
  logic        converter_enable_reg;
  logic        start_conversion_reg;
  logic        auto_trigger_enable_reg;
  logic        conversion_done_flag_reg;
  logic        done_interrupt_enable_reg;
  logic [2:0]  clock_divider_select_reg;
  logic [2:0]  trigger_source_select_reg;
  logic [9:0]  conversion_result_reg;
  logic        result_lock_reg;
  logic        first_done_reg;
  logic [4:0]  active_select_reg;
  logic [4:0]  cycle_reg;
  logic        trig_level_reg;
  logic        done_pulse_reg;
  logic        ack_reg;
  adcc_state_t state_reg;

  logic        tick;
  logic        wr_ctrl;
  logic        bus_go;
  logic        trig_level;
  logic        trig_rise;
  logic        start_req;
  logic        conv_end;
  logic [4:0]  conv_len;
  logic [7:0]  high_byte;
  logic [7:0]  low_byte;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  // Each access waits one cycle so read data come from a flop.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign bus_go          = (avs_read || avs_write) && !ack_reg;
  assign wr_ctrl         = bus_go && avs_write && avs_address == {1'b0, ADCC_OFF_CONTROL};

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= bus_go;
  end

  // Read data path; unmapped offsets return zero.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= '0;
    else if (bus_go && avs_read)
    begin
      unique case (avs_address)
        {1'b0, ADCC_OFF_INPUT_SELECT}:
          avs_readdata <= {24'h0, 2'b00, left_adjust_reg, input_gain_select_reg};
        {1'b0, ADCC_OFF_CONTROL}:
          avs_readdata <= {24'h0, converter_enable_reg, start_conversion_reg,
                           auto_trigger_enable_reg, conversion_done_flag_reg,
                           done_interrupt_enable_reg, clock_divider_select_reg};
        {1'b0, ADCC_OFF_RESULT_LOW}:  avs_readdata <= {24'h0, low_byte};
        {1'b0, ADCC_OFF_RESULT_HIGH}: avs_readdata <= {24'h0, high_byte};
        ADCC_OFF_TRIG_SRC:
          avs_readdata <= {24'h0, trigger_source_select_reg, 5'h00};
        default: avs_readdata <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Software fields
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      input_gain_select_reg     <= 5'h00;
      left_adjust_reg           <= 1'b0;
      trigger_source_select_reg <= 3'h0;
    end
    else if (bus_go && avs_write)
    begin
      if (avs_address == {1'b0, ADCC_OFF_INPUT_SELECT})
      begin
        input_gain_select_reg <= avs_writedata[4:0];
        left_adjust_reg       <= avs_writedata[ADCC_BIT_LEFT_ADJ];
      end
      if (avs_address == ADCC_OFF_TRIG_SRC)
        trigger_source_select_reg <= avs_writedata[7:5];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      converter_enable_reg      <= 1'b0;
      auto_trigger_enable_reg   <= 1'b0;
      done_interrupt_enable_reg <= 1'b0;
      clock_divider_select_reg  <= 3'h0;
    end
    else if (wr_ctrl)
    begin
      converter_enable_reg      <= avs_writedata[ADCC_BIT_ENABLE];
      auto_trigger_enable_reg   <= avs_writedata[ADCC_BIT_AUTO];
      done_interrupt_enable_reg <= avs_writedata[ADCC_BIT_DONE_IE];
      clock_divider_select_reg  <= avs_writedata[2:0];
    end
  end

  assign core_power = converter_enable_reg;

  // ---------------------------------------------------------------
  // Trigger logic
  // ---------------------------------------------------------------
  // source select and free running
  // Free running follows the completion pulse, not the flag level, so it
  // retriggers even if software leaves the flag set, and selecting it never
  // makes an edge.
  always_comb
  begin
    if (trigger_source_select_reg == ADCC_FREE_RUNNING)
      trig_level = done_pulse_reg;
    else
      trig_level = trigger_sources[trigger_source_select_reg];
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      trig_level_reg <= 1'b0;
    else
      trig_level_reg <= trig_level;
  end

  // Completion pulse delayed by one cycle, when the sequencer is idle again.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      done_pulse_reg <= 1'b0;
    else
      done_pulse_reg <= conv_end;
  end

  assign trig_rise = auto_trigger_enable_reg && trig_level && !trig_level_reg &&
                     !(wr_ctrl || (bus_go && avs_write && avs_address == ADCC_OFF_TRIG_SRC));

  assign start_req = (wr_ctrl && avs_writedata[ADCC_BIT_START] && avs_writedata[ADCC_BIT_ENABLE]) ||
                     (converter_enable_reg && trig_rise);

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  adcc_clock_divider #(
    .WIDTH (7)
  ) u_div (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .run            (state_reg == ADCC_CONV),
    .divider_select (clock_divider_select_reg),
    .tick           (tick)
  );

  assign conv_len = first_done_reg ? ADCC_NORM_CYCLES : ADCC_FIRST_CYCLES;
  assign conv_end = state_reg == ADCC_CONV && tick && cycle_reg == conv_len - 5'h01;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg            <= ADCC_IDLE;
      start_conversion_reg <= 1'b0;
      cycle_reg            <= 5'h00;
    end
    else if (!converter_enable_reg && state_reg == ADCC_CONV || wr_ctrl && !avs_writedata[ADCC_BIT_ENABLE])
    begin
      state_reg            <= ADCC_IDLE;
      start_conversion_reg <= 1'b0;
      cycle_reg            <= 5'h00;
    end
    else if (state_reg == ADCC_IDLE)
    begin
      if (start_req)
      begin
        state_reg            <= ADCC_CONV;
        start_conversion_reg <= 1'b1;
        cycle_reg            <= 5'h00;
      end
    end
    else if (conv_end)
    begin
      state_reg            <= ADCC_IDLE;
      start_conversion_reg <= 1'b0;
      cycle_reg            <= 5'h00;
    end
    else if (tick)
      cycle_reg <= cycle_reg + 5'h01;
  end

  // First-conversion marker is cleared whenever the converter is off.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      first_done_reg <= 1'b0;
    else if (!converter_enable_reg)
      first_done_reg <= 1'b0;
    else if (conv_end)
      first_done_reg <= 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      active_select_reg <= 5'h00;
    else if (state_reg == ADCC_IDLE && start_req)
      active_select_reg <= input_gain_select_reg;
  end

  // differential pairs and gain
  // The core decodes pairs and gain from the held code.
  assign core_input_gain_select = active_select_reg;
  assign core_differential      = active_select_reg >= ADCC_DIFF_FIRST &&
                                  active_select_reg <= ADCC_DIFF_LAST;
  assign core_sample            = conv_end;

  // ---------------------------------------------------------------
  // Result registers and flag
  // ---------------------------------------------------------------
  // lock after low byte read
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      result_lock_reg <= 1'b0;
    else if (bus_go && avs_read && avs_address == {1'b0, ADCC_OFF_RESULT_HIGH})
      result_lock_reg <= 1'b0;
    else if (bus_go && avs_read && avs_address == {1'b0, ADCC_OFF_RESULT_LOW})
      result_lock_reg <= 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      conversion_result_reg <= 10'h000;
    else if (conv_end && !result_lock_reg)
      conversion_result_reg <= core_result;
  end

  // vector or write-one clears, set wins
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      conversion_done_flag_reg <= 1'b0;
    else if (conv_end && !result_lock_reg)
      conversion_done_flag_reg <= 1'b1;
    else if (done_vector_ack || (wr_ctrl && avs_writedata[ADCC_BIT_DONE]))
      conversion_done_flag_reg <= 1'b0;
  end

  assign done_irq = conversion_done_flag_reg && done_interrupt_enable_reg && global_irq_enable;

  assign high_byte = left_adjust_reg ? conversion_result_reg[9:2]
                                     : {6'h00, conversion_result_reg[9:8]};
  assign low_byte  = left_adjust_reg ? {conversion_result_reg[1:0], 6'h00}
                                     : conversion_result_reg[7:0];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence conv_finish_s;
    conv_end && !result_lock_reg;
  endsequence

  done_sets_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_finish_s |=> conversion_done_flag_reg && !start_conversion_reg)
    else $error("done flag did not set at conversion end");
  lock_holds_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    result_lock_reg |=> $stable(conversion_result_reg))
    else $error("result changed while locked");
  abort_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !converter_enable_reg && !wr_ctrl |=> state_reg == ADCC_IDLE)
    else $error("conversion ran while disabled");
  busy_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_go && avs_read && avs_address == {1'b0, ADCC_OFF_CONTROL}
    |=> avs_readdata[ADCC_BIT_START] == $past(state_reg == ADCC_CONV))
    else $error("start bit does not follow busy");
  sel_held_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ADCC_CONV && $past(state_reg) == ADCC_CONV |-> $stable(active_select_reg))
    else $error("channel changed mid conversion");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    done_irq |-> conversion_done_flag_reg && global_irq_enable)
    else $error("interrupt without its causes");
  left_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    left_adjust_reg |-> high_byte == conversion_result_reg[9:2] && low_byte[5:0] == 6'h00)
    else $error("left adjust layout wrong");
  right_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !left_adjust_reg |-> high_byte[7:2] == 6'h00 && low_byte == conversion_result_reg[7:0])
    else $error("right adjust layout wrong");
  first_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_end |-> cycle_reg == (first_done_reg ? 5'd12 : 5'd24))
    else $error("conversion length wrong");
  clear_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_ctrl && avs_writedata[ADCC_BIT_DONE] && !conv_end |=> !conversion_done_flag_reg)
    else $error("write one did not clear flag");
endmodule // adcc_top
`default_nettype wire

//--- verification/adcc_core_model.sv
// Behavioural model of the conversion core behind the control block.
// Assumes the block holds the channel select steady for a whole conversion.
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model
  import adcc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       core_power,
  input  wire logic       core_sample,
  input  wire logic [4:0] core_input_gain_select,
  input  wire logic       core_differential,
  output logic [9:0]      core_result
);
  logic [9:0] drift_reg;

  // An unpowered core shows a changing pattern, so a stale code never looks valid.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      drift_reg <= 10'h155;
    else
      drift_reg <= ~drift_reg + 10'h001;
  end

  // channel to code
  // Every select code gives its own code, so a wrong channel shows in the result.
  assign core_result = core_power ? {core_input_gain_select, ~core_input_gain_select}
                                  : drift_reg;
endmodule // adcc_core_model
`default_nettype wire

//--- verification/adcc_top_tb.sv
// Self-checking bench for the converter control block over Avalon-MM.
// Assumes the core model above and the register offsets of the package.
`timescale 1ns/1ps
`default_nettype none
module adcc_top_tb
  import adcc_pkg::*;
;
  localparam logic [4:0] sel_a  = {1'b0, ADCC_OFF_INPUT_SELECT};
  localparam logic [4:0] ctl_a  = {1'b0, ADCC_OFF_CONTROL};
  localparam logic [4:0] low_a  = {1'b0, ADCC_OFF_RESULT_LOW};
  localparam logic [4:0] high_a = {1'b0, ADCC_OFF_RESULT_HIGH};
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:1]  trigger_sources = 7'h00;
  logic        global_irq_enable = 1'b0;
  logic        done_vector_ack = 1'b0;
  logic [9:0]  core_result;
  logic        core_power;
  logic        core_sample;
  logic [4:0]  core_input_gain_select;
  logic        core_differential;
  logic        done_irq;
  int          num_errors = 0;
  int          comparisons = 0;
  int          n;
  logic        dif;
  logic [4:0]  codes [8] = '{5'h07, 5'h08, 5'h0F, 5'h10, 5'h1D, 5'h1E, 5'h1F, 5'h00};

  // 40 MHz system clock.
  always #12.5 sys_clk = ~sys_clk;

  adcc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .trigger_sources(trigger_sources), .global_irq_enable(global_irq_enable),
    .done_vector_ack(done_vector_ack), .core_result(core_result),
    .core_power(core_power), .core_sample(core_sample),
    .core_input_gain_select(core_input_gain_select),
    .core_differential(core_differential), .done_irq(done_irq));

  adcc_core_model core (.sys_clk(sys_clk), .rst_n(rst_n), .core_power(core_power),
    .core_sample(core_sample), .core_input_gain_select(core_input_gain_select),
    .core_differential(core_differential), .core_result(core_result));

  // ---------------------------------------------------------------
  // Bus and checking tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // The request is held from the edge after the call until the rising edge at
  // which waitrequest is sampled low; read data are taken at that same edge.
  task automatic bus_op(input logic wr, input logic [4:0] a, input logic [7:0] d,
                        output logic [31:0] q);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h000000, d};
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && k < 50)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 50)
      num_errors++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus_op(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string what);
    logic [31:0] q;
    bus_op(1'b0, a, 8'h00, q);
    check(what, q, {24'h000000, e});
  endtask

  // Counts cycles to the end-of-conversion pulse; -1 when it never comes.
  task automatic wait_sample(input int lim, output int cnt, output logic d);
    cnt = 0;
    // Step off the edge first, so a pulse that ends at this edge is not counted.
    @(negedge sys_clk);
    while (core_sample !== 1'b1 && cnt < lim)
    begin
      @(negedge sys_clk);
      cnt++;
    end
    if (cnt >= lim)
      cnt = -1;
    d = core_differential;
    @(posedge sys_clk);
  endtask

  task automatic end_test(input string name);
    $display("test %s finished, errors so far %0d", name, num_errors);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog sized well above the longest run of the sequence below.
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(ctl_a, 8'h00, "control reset");
    rdc(sel_a, 8'h00, "select reset");
    rdc(low_a, 8'h00, "low reset");
    rdc(high_a, 8'h00, "high reset");
    wr(5'h14, 8'hFF);
    rdc(5'h14, 8'h00, "unmapped read");
    rdc(ctl_a, 8'h00, "control after unmapped write");
    check("power at reset", core_power, 1'b0);
    end_test("reset");
    // Enable and start together: the long first conversion, code 0x345.
    wr(sel_a, 8'h1A);
    wr(ctl_a, 8'hC0);
    check("power on", core_power, 1'b1);
    wait_sample(200, n, dif);
    check("first length", (n >= 48) && (n <= 56), 32'h1);
    check("diff code 1A", dif, 1'b1);
    repeat (2) @(posedge sys_clk);
    rdc(ctl_a, 8'h90, "done after first");
    rdc(low_a, 8'h45, "right low");
    rdc(high_a, 8'h03, "right high");
    wr(sel_a, 8'h3A);
    rdc(low_a, 8'h40, "left low");
    rdc(high_a, 8'hD1, "left high");
    wr(sel_a, 8'h1A);
    end_test("first conversion");
    // Flag clearing paths and the interrupt request.
    wr(ctl_a, 8'h88);
    rdc(ctl_a, 8'h98, "flag kept on zero write");
    @(posedge sys_clk);
    global_irq_enable <= 1'b1;
    @(negedge sys_clk);
    check("irq raised", done_irq, 1'b1);
    @(posedge sys_clk);
    global_irq_enable <= 1'b0;
    @(negedge sys_clk);
    check("irq masked", done_irq, 1'b0);
    @(posedge sys_clk);
    global_irq_enable <= 1'b1;
    done_vector_ack <= 1'b1;
    @(posedge sys_clk);
    done_vector_ack <= 1'b0;
    @(negedge sys_clk);
    check("irq after vector", done_irq, 1'b0);
    rdc(ctl_a, 8'h88, "flag cleared by vector");
    end_test("flag");
    // A low-byte read locks both bytes and the flag until the high byte is read.
    rdc(low_a, 8'h45, "low before lock");
    wr(sel_a, 8'h05);
    wr(ctl_a, 8'hC8);
    wait_sample(200, n, dif);
    check("normal length", (n >= 24) && (n <= 32), 32'h1);
    repeat (2) @(posedge sys_clk);
    rdc(ctl_a, 8'h88, "flag held by lock");
    rdc(high_a, 8'h03, "high kept by lock");
    wr(ctl_a, 8'hC8);
    wait_sample(200, n, dif);
    repeat (2) @(posedge sys_clk);
    rdc(ctl_a, 8'h98, "flag after unlock");
    rdc(low_a, 8'hBA, "low after unlock");
    rdc(high_a, 8'h00, "high after unlock");
    wr(ctl_a, 8'h98);
    rdc(ctl_a, 8'h88, "flag cleared by one");
    end_test("lock");
    // Channel change and a zero start write in mid conversion.
    wr(ctl_a, 8'hC8);
    rdc(ctl_a, 8'hC8, "busy start bit");
    wr(sel_a, 8'h06);
    check("channel held", core_input_gain_select, 5'h05);
    wr(ctl_a, 8'h88);
    rdc(ctl_a, 8'hC8, "zero start ignored");
    wait_sample(200, n, dif);
    check("conversion kept", n >= 0, 32'h1);
    repeat (2) @(posedge sys_clk);
    rdc(low_a, 8'hBA, "old channel low");
    rdc(high_a, 8'h00, "old channel high");
    wr(ctl_a, 8'h98);
    end_test("channel hold");
    // Every prescaler code with a spread of channel codes.
    for (int i = 0; i < 8; i++)
    begin
      wr(sel_a, {3'h0, codes[i]});
      wr(ctl_a, 8'hC8 | {5'h00, i[2:0]});
      wait_sample(3000, n, dif);
      check("scaled length", (n >= 13 * ((i < 2) ? 2 : (1 << i)) - 2) &&
            (n <= 14 * ((i < 2) ? 2 : (1 << i)) + 4), 32'h1);
      check("differential", dif, (codes[i] >= 5'h08) && (codes[i] <= 5'h1D));
      repeat (2) @(posedge sys_clk);
      rdc(low_a, {codes[i][2:0], ~codes[i]}, "code low");
      rdc(high_a, {6'h00, codes[i][4:3]}, "code high");
      wr(ctl_a, 8'h98 | {5'h00, i[2:0]});
    end
    end_test("prescaler");
    // Clearing enable in mid conversion aborts it.
    wr(ctl_a, 8'hC0);
    repeat (10) @(posedge sys_clk);
    wr(ctl_a, 8'h00);
    check("power off", core_power, 1'b0);
    wait_sample(100, n, dif);
    check("aborted", n, -1);
    rdc(ctl_a, 8'h00, "control after abort");
    end_test("abort");
    // Auto trigger on source 1, then free running.
    wr(ADCC_OFF_TRIG_SRC, 8'h20);
    wr(ctl_a, 8'hA0);
    trigger_sources <= 7'h01;
    wait_sample(200, n, dif);
    check("triggered", n >= 0, 32'h1);
    trigger_sources <= 7'h00;
    repeat (2) @(posedge sys_clk);
    rdc(ctl_a, 8'hB0, "flag after trigger");
    wr(ADCC_OFF_TRIG_SRC, 8'h00);
    wait_sample(100, n, dif);
    check("no switch trigger", n, -1);
    wr(ctl_a, 8'hE0);
    wait_sample(200, n, dif);
    check("free run first", n >= 0, 32'h1);
    wait_sample(200, n, dif);
    check("free run next", n >= 0, 32'h1);
    wr(ctl_a, 8'h00);
    end_test("trigger");
    print_verdict();
  end
endmodule // adcc_top_tb
`default_nettype wire
